// ### logic/word_convert_defines.svh
// register offsets, field positions and reset values of the word conversion unit
// assumes byte addressing over a 32-bit AHB-Lite bus, one register per aligned word
`ifndef WORD_CONVERT_DEFINES_SVH
`define WORD_CONVERT_DEFINES_SVH

// register byte offsets
`define WC_CTRL_OFS       12'h000
`define WC_SRC_OFS        12'h004
`define WC_CW_OFS         12'h008
`define WC_FLAGS_OFS      12'h00C
`define WC_ENCRES_OFS     12'h010
`define WC_IRQ_STAT_OFS   12'h014
`define WC_IRQ_MASK_OFS   12'h018
`define WC_OUT_BASE       12'h080
`define WC_IN_BASE        12'h100
`define WC_AREA_BYTES     12'h080

// control register fields
`define WC_CTRL_RUN       0
`define WC_CTRL_ONCE      1
`define WC_CTRL_OP_LSB    2
`define WC_CTRL_WIDTH     4

// flags register fields
`define WC_FLAG_ERR       0
`define WC_FLAG_EQ        1
`define WC_FLAG_NEG       2

// interrupt status and mask fields
`define WC_IRQ_DONE       0
`define WC_IRQ_ERR        1
`define WC_IRQ_WIDTH      2

// control word digits
`define WC_CW_START_LSB   0
`define WC_CW_COUNT_LSB   4
`define WC_CW_DIR_LSB     8
`define WC_CW_MODE_LSB    12

// data area depth in 16-bit words
`define WC_AREA_WORDS     32

// reset values
`define WC_CTRL_RST       4'h0
`define WC_WORD_RST       16'h0000
`define WC_IRQ_MASK_RST   2'h0

`endif

// ### logic/word_convert_pkg.sv
// types shared by the word conversion unit
// assumes the defines header is compiled alongside
`include "word_convert_defines.svh"

package word_convert_pkg;

  // operation selected in the control register
  typedef enum logic [1:0] {
    OP_SIGN_EXTEND,
    OP_ONE_HOT_DECODE,
    OP_PRIORITY_LOCATE,
    OP_IDLE
  } op_t;

  typedef logic [`WC_AREA_WORDS-1:0][15:0] area_t;

  // complete state of the unit, registered as one vector
  typedef struct packed {
    logic [`WC_CTRL_WIDTH-1:0] ctrl;
    logic [15:0]               src;
    logic [15:0]               cw;
    logic                      faultIndicator;
    logic                      eqFlag;
    logic                      negFlag;
    logic [15:0]               encResult;
    logic [`WC_IRQ_WIDTH-1:0]  irqStatus;
    logic [`WC_IRQ_WIDTH-1:0]  irqMask;
    logic                      runPrev;
    area_t                     outWords;
    area_t                     inWords;
    logic                      addrPend;
    logic                      addrWrite;
    logic [11:0]               addr;
    logic                      readWait;
    logic                      hreadyout;
    logic [31:0]               hrdata;
    logic                      irq;
  } state_t;

endpackage : word_convert_pkg

// ### logic/word_convert.sv
// word conversion unit: sign extension, one-hot decoding and priority locating
// assumes a single AHB-Lite master on the same clock; hready is this slave's hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "word_convert_defines.svh"

module word_convert (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq
);

  word_convert_pkg::state_t q;
  word_convert_pkg::state_t n;

  // search a vector for its highest or lowest set bit; msb {found, position}
  function automatic logic [8:0] locateBit(input logic [255:0] vec, input logic lowest);
    logic [7:0] pos;
    logic       found;
    pos   = 8'h00;
    found = 1'b0;
    for (int k = 0; k < 256; k++) begin
      if (vec[k] && (!lowest || !found)) begin
        pos   = 8'(k);
        found = 1'b1;
      end
    end
    return {found, pos};
  endfunction : locateBit

  // check the control word fields against the ranges of the chosen operation
  function automatic logic controlValid(input logic [15:0] cw, input logic isLocate);
    logic [3:0] start;
    logic [3:0] count;
    logic [3:0] dir;
    logic [3:0] mode;
    start = cw[`WC_CW_START_LSB +: 4];
    count = cw[`WC_CW_COUNT_LSB +: 4];
    dir   = cw[`WC_CW_DIR_LSB +: 4];
    mode  = cw[`WC_CW_MODE_LSB +: 4];
    if (mode == 4'h0) begin
      controlValid = (start <= 4'h3) && (count <= 4'h3);
    end else if (mode == 4'h1) begin
      controlValid = (start <= 4'h1) && (count <= 4'h1);
    end else begin
      controlValid = 1'b0;
    end
    // the decoder has no direction digit, so anything but 0 there is out of range
    if (isLocate ? (dir > 4'h1) : (dir != 4'h0)) begin
      controlValid = 1'b0;
    end
  endfunction : controlValid

  // next-state logic: bus slave, then conversion, then interrupt state
  always_comb begin
    logic                       runNow;
    logic                       ok;
    logic [1:0]                 start2;
    logic [1:0]                 count2;
    logic [1:0]                 idx;
    logic                       lowest;
    logic                       byteMode;
    logic [3:0]                 digit;
    logic [7:0]                 byteVal;
    logic [8:0]                 hit;
    logic [15:0]                res;
    logic [31:0]                rdata;
    logic [11:0]                ofs;
    word_convert_pkg::area_t    decoded;
    word_convert_pkg::op_t      op;
    logic [`WC_IRQ_WIDTH-1:0]   irqSet;
    runNow   = 1'b0;
    ok       = 1'b0;
    start2   = 2'h0;
    count2   = 2'h0;
    idx      = 2'h0;
    lowest   = 1'b0;
    byteMode = 1'b0;
    digit    = 4'h0;
    byteVal  = 8'h00;
    hit      = 9'h000;
    res      = 16'h0000;
    rdata    = 32'h0000_0000;
    ofs      = 12'h000;
    decoded  = q.outWords;
    op       = word_convert_pkg::op_t'(q.ctrl[`WC_CTRL_OP_LSB +: 2]);
    irqSet   = '0;
    n        = q;

    // read data, registered one cycle after the address so a prior write is seen
    ofs = q.addr;
    if (ofs == `WC_CTRL_OFS) begin
      rdata = {28'h0000000, q.ctrl};
    end else if (ofs == `WC_SRC_OFS) begin
      rdata = {16'h0000, q.src};
    end else if (ofs == `WC_CW_OFS) begin
      rdata = {16'h0000, q.cw};
    end else if (ofs == `WC_FLAGS_OFS) begin
      rdata = {29'h00000000, q.negFlag, q.eqFlag, q.faultIndicator};
    end else if (ofs == `WC_ENCRES_OFS) begin
      rdata = {16'h0000, q.encResult};
    end else if (ofs == `WC_IRQ_STAT_OFS) begin
      rdata = {30'h00000000, q.irqStatus};
    end else if (ofs == `WC_IRQ_MASK_OFS) begin
      rdata = {30'h00000000, q.irqMask};
    end else if (ofs >= `WC_OUT_BASE && ofs < `WC_OUT_BASE + `WC_AREA_BYTES) begin
      rdata = {16'h0000, q.outWords[ofs[6:2]]};
    end else if (ofs >= `WC_IN_BASE && ofs < `WC_IN_BASE + `WC_AREA_BYTES) begin
      rdata = {16'h0000, q.inWords[ofs[6:2]]};
    end

    // read data phase: one wait state, then data with hreadyout high
    if (q.readWait) begin
      n.hrdata    = rdata;
      n.hreadyout = 1'b1;
      n.readWait  = 1'b0;
      n.addrPend  = 1'b0;
    end

    // write data phase completes with zero wait states; unmapped writes vanish
    if (q.addrPend && q.addrWrite) begin
      n.addrPend = 1'b0;
      if (ofs == `WC_CTRL_OFS) begin
        n.ctrl = hwdata[`WC_CTRL_WIDTH-1:0];
      end else if (ofs == `WC_SRC_OFS) begin
        n.src = hwdata[15:0];
      end else if (ofs == `WC_CW_OFS) begin
        n.cw = hwdata[15:0];
      end else if (ofs == `WC_ENCRES_OFS) begin
        n.encResult = hwdata[15:0];
      end else if (ofs == `WC_IRQ_STAT_OFS) begin
        n.irqStatus = q.irqStatus & ~hwdata[`WC_IRQ_WIDTH-1:0];
      end else if (ofs == `WC_IRQ_MASK_OFS) begin
        n.irqMask = hwdata[`WC_IRQ_WIDTH-1:0];
      end else if (ofs >= `WC_IN_BASE && ofs < `WC_IN_BASE + `WC_AREA_BYTES) begin
        n.inWords[ofs[6:2]] = hwdata[15:0];
      end
    end

    // address phase: only word transfers are expected, narrower ones act as words
    if (hsel && htrans[1] && hready) begin
      n.addrPend  = 1'b1;
      n.addrWrite = hwrite;
      n.addr      = (haddr[31:12] == 20'h00000) ? {haddr[11:2], 2'b00} : 12'hFFC;
      if (!hwrite) begin
        n.hreadyout = 1'b0;
        n.readWait  = 1'b1;
      end
    end

    // execution trigger: level runs every cycle, once mode only on the rise
    n.runPrev = q.ctrl[`WC_CTRL_RUN];
    runNow    = q.ctrl[`WC_CTRL_RUN] && (!q.ctrl[`WC_CTRL_ONCE] || !q.runPrev);

    // control word fields, meaningful only once validated
    start2   = q.cw[`WC_CW_START_LSB +: 2];
    count2   = q.cw[`WC_CW_COUNT_LSB +: 2];
    lowest   = q.cw[`WC_CW_DIR_LSB];
    byteMode = q.cw[`WC_CW_MODE_LSB];

    if (runNow) begin
      case (op)
        word_convert_pkg::OP_SIGN_EXTEND: begin
          n.outWords[0]      = q.src;
          n.outWords[1]      = q.src[15] ? 16'hFFFF : 16'h0000;
          n.faultIndicator   = 1'b0;
          n.eqFlag           = (q.src == 16'h0000);
          n.negFlag          = q.src[15];
          irqSet[`WC_IRQ_DONE] = 1'b1;
        end
        word_convert_pkg::OP_ONE_HOT_DECODE: begin
          ok = controlValid(q.cw, 1'b0);
          if (!byteMode) begin
            for (int i = 0; i < 4; i++) begin
              if (2'(i) <= count2) begin
                idx        = start2 + 2'(i);
                digit      = q.src[{idx, 2'b00} +: 4];
                decoded[i] = 16'h0001 << digit;
              end
            end
          end else begin
            for (int i = 0; i < 2; i++) begin
              if (2'(i) <= count2) begin
                // second byte after byte 1 wraps back to byte 0
                byteVal = start2[0] ^ 1'(i) ? q.src[15:8] : q.src[7:0];
                for (int w = 0; w < 16; w++) begin
                  decoded[16*i+w] = (byteVal[7:4] == 4'(w)) ? (16'h0001 << byteVal[3:0]) : 16'h0000;
                end
              end
            end
          end
          // results land only in the words this run owns; a bad word writes none
          if (ok) begin
            n.outWords = decoded;
          end
          n.faultIndicator         = !ok;
          irqSet[`WC_IRQ_DONE]     = 1'b1;
          irqSet[`WC_IRQ_ERR]      = !ok;
        end
        word_convert_pkg::OP_PRIORITY_LOCATE: begin
          ok  = controlValid(q.cw, 1'b1);
          res = q.encResult;
          if (!byteMode) begin
            for (int i = 0; i < 4; i++) begin
              if (2'(i) <= count2) begin
                hit = locateBit({240'h0, q.inWords[i]}, lowest);
                idx = start2 + 2'(i);
                if (!hit[8]) begin
                  ok = 1'b0;
                end
                res[{idx, 2'b00} +: 4] = hit[3:0];
              end
            end
          end else begin
            for (int i = 0; i < 2; i++) begin
              if (2'(i) <= count2) begin
                hit = locateBit(q.inWords[16*i +: 16], lowest);
                if (!hit[8]) begin
                  ok = 1'b0;
                end
                if (start2[0] ^ 1'(i)) begin
                  res[15:8] = hit[7:0];
                end else begin
                  res[7:0] = hit[7:0];
                end
              end
            end
          end
          // a failed search leaves the previous result untouched
          if (ok) begin
            n.encResult = res;
          end
          n.faultIndicator     = !ok;
          irqSet[`WC_IRQ_DONE] = 1'b1;
          irqSet[`WC_IRQ_ERR]  = !ok;
        end
        default: begin
          irqSet = '0;
        end
      endcase
    end

    // sticky events: a set in the same cycle as a clear wins
    n.irqStatus = n.irqStatus | irqSet;
    n.irq       = |(n.irqStatus & n.irqMask);
  end

  // single register for the whole state vector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q                <= '0;
      q.ctrl           <= `WC_CTRL_RST;
      q.src            <= `WC_WORD_RST;
      q.cw             <= `WC_WORD_RST;
      q.encResult      <= `WC_WORD_RST;
      q.irqMask        <= `WC_IRQ_MASK_RST;
      q.hreadyout      <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register; the slave never signals an error
  assign hreadyout = q.hreadyout;
  assign hrdata    = q.hrdata;
  assign irq       = q.irq;
  assign hresp     = 1'b0;

endmodule : word_convert

`default_nettype wire

// ### tb/word_convert_props.sv
// checker: bus timing, read data shape and interrupt release of word_convert
// assumes binding to word_convert, whose hready is its own hreadyout
`timescale 1ns/1ps
`default_nettype none

module word_convert_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic        taken;
  logic        wrPhase_q;
  logic [31:0] rdAddr_q;

  // transfer accepted at this edge
  assign taken = hsel && htrans[1] && hready;

  // what the data phase in flight belongs to
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPhase_q <= 1'h0;
      rdAddr_q  <= 32'h00000000;
    end else begin
      wrPhase_q <= taken && hwrite;
      if (taken && !hwrite) rdAddr_q <= haddr;
    end
  end

  property p_okay; hresp == 1'h0; endproperty
  property p_wr_nowait; taken && hwrite |=> hreadyout; endproperty
  property p_rd_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  property p_wait_cause; !hreadyout |-> $past(taken && !hwrite); endproperty
  property p_rd_hold; !$stable(hrdata) |-> $rose(hreadyout); endproperty
  property p_upper; $rose(hreadyout) |-> hrdata[31:16] == 16'h0000; endproperty
  property p_unmapped; $rose(hreadyout) && rdAddr_q[31:12] != 20'h00000 |-> hrdata == 32'h0; endproperty
  // irq only drops once software has cleared or masked something
  property p_irq_fall; $fell(irq) |-> $past(wrPhase_q) || $past(wrPhase_q, 2); endproperty

  a_okay: assert property (p_okay) else $error("error response");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  a_wait_cause: assert property (p_wait_cause) else $error("stray wait");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_upper: assert property (p_upper) else $error("upper half set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");

  c_read: cover property (taken && !hwrite);
  c_write: cover property (taken && hwrite);
  c_irq: cover property ($rose(irq));
endmodule : word_convert_props

bind word_convert word_convert_props u_props (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of word_convert, registers reached over AHB-Lite
// assumes package, defines and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "word_convert_defines.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic [19:0] upper;
  int          failures;
  int          comparisons;

  // lone slave: its hreadyout is the bus hready; every access is a word
  word_convert uut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // address phase held until the slave takes it
  task automatic ap(input logic [11:0] a, input logic w);
    hsel   <= 1'h1;
    haddr  <= {upper, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
  endtask : ap

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ap(a, 1'h1);
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
  endtask : wr

  // data taken at the edge where hready is seen high again
  task automatic rc(input logic [11:0] a, input logic [31:0] ex, input string nm);
    ap(a, 1'h0);
    do @(posedge clk); while (hreadyout !== 1'h1);
    `CHK(nm, ex, hrdata)
    `CHK("hresp", 1'h0, hresp)
  endtask : rc

  // irq is registered, so allow it to settle first
  task automatic irqChk(input logic ex);
    repeat (2) @(posedge clk);
    `CHK("irq", ex, irq)
  endtask : irqChk

  // one execution on the rise of run, then run released
  task automatic exec(input word_convert_pkg::op_t op);
    wr(`WC_CTRL_OFS, {28'h0, op, 2'h2});
    wr(`WC_CTRL_OFS, {28'h0, op, 2'h3});
    wr(`WC_CTRL_OFS, {28'h0, op, 2'h2});
  endtask : exec

  function automatic logic [11:0] outAddr(input int i);
    return `WC_OUT_BASE + 12'(4 * i);
  endfunction : outAddr

  // four digits from digit 2, wrapping past digit 3
  task automatic t_dec4();
    logic [15:0] ex[4] = '{16'h0400, 16'h0200, 16'h0080, 16'h0008};
    rc(`WC_IRQ_MASK_OFS, 32'h0, "mask");
    wr(`WC_SRC_OFS, 32'h9A37);
    wr(`WC_CW_OFS, 32'h0032);
    exec(word_convert_pkg::OP_ONE_HOT_DECODE);
    for (int i = 0; i < 5; i++) begin
      rc(outAddr(i), (i < 4) ? {16'h0, ex[i]} : 32'h0, "word");
    end
  endtask : t_dec4

  // two bytes from byte 1, the second wraps to byte 0
  task automatic t_dec8();
    wr(`WC_CW_OFS, 32'h1011);
    exec(word_convert_pkg::OP_ONE_HOT_DECODE);
    for (int i = 0; i < 32; i++) begin
      rc(outAddr(i), (i == 9) ? 32'h0400 : (i == 19) ? 32'h0080 : 32'h0, "block");
    end
  endtask : t_dec8

  // single digit, then control words out of range leave results alone
  task automatic t_err();
    logic [15:0] bad[6] = '{16'h2000, 16'h0040, 16'h0004, 16'h0100, 16'h1020, 16'h1002};
    wr(`WC_CW_OFS, 32'h0);
    exec(word_convert_pkg::OP_ONE_HOT_DECODE);
    rc(outAddr(0), 32'h0080, "single");
    rc(`WC_FLAGS_OFS, 32'h0, "flags");
    foreach (bad[i]) begin
      wr(`WC_CW_OFS, {16'h0, bad[i]});
      exec(word_convert_pkg::OP_ONE_HOT_DECODE);
      rc(`WC_FLAGS_OFS, 32'h1, "fault");
      rc(outAddr(9), 32'h0400, "kept");
    end
  endtask : t_err

  // negative, zero and largest positive; first run also clears the fault
  task automatic t_sign();
    logic [15:0] src[3] = '{16'h8000, 16'h0000, 16'h7FFF};
    logic [15:0] hi[3]  = '{16'hFFFF, 16'h0000, 16'h0000};
    logic [2:0]  fl[3]  = '{3'h4, 3'h2, 3'h0};
    foreach (src[i]) begin
      wr(`WC_SRC_OFS, {16'h0, src[i]});
      exec(word_convert_pkg::OP_SIGN_EXTEND);
      rc(outAddr(0), {16'h0, src[i]}, "low");
      rc(outAddr(1), {16'h0, hi[i]}, "high");
      rc(`WC_FLAGS_OFS, {29'h0, fl[i]}, "flags");
    end
  endtask : t_sign

  // highest, lowest, wrapped digits, then a zero word faults
  task automatic t_loc();
    wr(`WC_IN_BASE, 32'h0300);
    wr(`WC_IN_BASE + 12'h004, 32'h8001);
    wr(`WC_IN_BASE + 12'h008, 32'h0010);
    wr(`WC_ENCRES_OFS, 32'h0005);
    wr(`WC_CW_OFS, 32'h0021);
    exec(word_convert_pkg::OP_PRIORITY_LOCATE);
    rc(`WC_ENCRES_OFS, 32'h4F95, "highest");
    wr(`WC_CW_OFS, 32'h0121);
    exec(word_convert_pkg::OP_PRIORITY_LOCATE);
    rc(`WC_ENCRES_OFS, 32'h4085, "lowest");
    wr(`WC_CW_OFS, 32'h0013);
    exec(word_convert_pkg::OP_PRIORITY_LOCATE);
    rc(`WC_ENCRES_OFS, 32'h908F, "wrap");
    wr(`WC_IN_BASE + 12'h004, 32'h0);
    exec(word_convert_pkg::OP_PRIORITY_LOCATE);
    rc(`WC_ENCRES_OFS, 32'h908F, "kept");
    rc(`WC_FLAGS_OFS, 32'h1, "fault");
    // byte mode: 16-word ranges, second byte wraps from byte 1 to byte 0
    wr(`WC_IN_BASE + 12'h044, 32'h0002);
    wr(`WC_CW_OFS, 32'h1011);
    exec(word_convert_pkg::OP_PRIORITY_LOCATE);
    rc(`WC_ENCRES_OFS, 32'h2411, "bytes");
    wr(`WC_CW_OFS, 32'h1100);
    exec(word_convert_pkg::OP_PRIORITY_LOCATE);
    rc(`WC_ENCRES_OFS, 32'h2408, "byte low");
    rc(`WC_FLAGS_OFS, 32'h0, "clear");
  endtask : t_loc

  // run held repeats each cycle; once runs on the rise, not the fall
  task automatic t_run();
    wr(`WC_CTRL_OFS, 32'h1);
    wr(`WC_SRC_OFS, 32'h0001);
    rc(outAddr(0), 32'h0001, "each");
    wr(`WC_SRC_OFS, 32'h8002);
    rc(outAddr(1), 32'hFFFF, "each");
    wr(`WC_CTRL_OFS, 32'h2);
    wr(`WC_CTRL_OFS, 32'h3);
    wr(`WC_SRC_OFS, 32'h0003);
    wr(`WC_CTRL_OFS, 32'h2);
    rc(outAddr(0), 32'h8002, "once");
  endtask : t_run

  // sticky status, mask, clear by one, unmapped and read-only writes
  task automatic t_irq();
    rc(`WC_IRQ_STAT_OFS, 32'h3, "status");
    irqChk(1'h0);
    wr(`WC_IRQ_MASK_OFS, 32'h1);
    irqChk(1'h1);
    wr(`WC_IRQ_STAT_OFS, 32'h1);
    irqChk(1'h0);
    rc(`WC_IRQ_STAT_OFS, 32'h2, "status");
    wr(`WC_IRQ_MASK_OFS, 32'h3);
    wr(`WC_IRQ_STAT_OFS, 32'h2);
    irqChk(1'h0);
    // idle op: no event, results left alone
    exec(word_convert_pkg::OP_IDLE);
    irqChk(1'h0);
    rc(outAddr(0), 32'h8002, "idle");
    exec(word_convert_pkg::OP_SIGN_EXTEND);
    irqChk(1'h1);
    upper = 20'h00001;
    rc(`WC_IRQ_MASK_OFS, 32'h0, "unmapped");
    wr(`WC_IRQ_MASK_OFS, 32'h0);
    upper = 20'h00000;
    rc(`WC_IRQ_MASK_OFS, 32'h3, "mask");
    wr(`WC_FLAGS_OFS, 32'h7);
    rc(`WC_FLAGS_OFS, 32'h0, "read only");
  endtask : t_irq

  task automatic end_sim();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  initial begin
    rst = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    upper = 20'h0;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_dec4();
    t_dec8();
    t_err();
    t_sign();
    t_loc();
    t_run();
    t_irq();
    end_sim();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("unexpected hang in watchdog");
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
